// >>> hdl/scs_params.svh
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

`define SCS_CLK_MHZ 40
`define SCS_RATE_WARP_KSPS 1000
`define SCS_RATE_NORMAL_KSPS 800
`define SCS_PER_WARP_CYC ((`SCS_CLK_MHZ * 1000) / `SCS_RATE_WARP_KSPS)
`define SCS_PER_NORMAL_CYC ((`SCS_CLK_MHZ * 1000) / `SCS_RATE_NORMAL_KSPS)
`define SCS_NBITS 16
`define SCS_TRIAL_DIV 2
`define SCS_WAKE_NS 200
`define SCS_WAKE_CYC ((`SCS_WAKE_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_STALE_US 1000
`define SCS_STALE_CYC (`SCS_STALE_US * `SCS_CLK_MHZ)

`define SCS_OFS_CTRL 5'h00
`define SCS_OFS_STATUS 5'h04
`define SCS_OFS_RESULT 5'h08
`define SCS_OFS_IRQ_STS 5'h0C
`define SCS_OFS_IRQ_EN 5'h10
`define SCS_OFS_IRQ_CLR 5'h14

`define SCS_IRQ_DONE 0
`define SCS_IRQ_REFUSED 1
`define SCS_IRQ_ABORT 2
`define SCS_STS_BUSY 0
`define SCS_STS_PDOWN 1
`define SCS_STS_STALE 2

`define SCS_CTRL_RST 2'h0
`define SCS_IEN_RST 3'h0
`define SCS_TRIAL_MSB 16'h8000
`define SCS_SB_MAX 16'hFFFF
`define SCS_SB_MIN 16'h0000
`define SCS_TC_FLIP 16'h8000

`endif

// >>> hdl/scs_pkg.sv
`default_nettype none
package scs_pkg;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_WARP = 2'h1,
    MODE_LOWPWR = 2'h2,
    MODE_RSVD = 2'h3
  } scs_mode_type;

  typedef enum logic [2:0] {
    ST_WAIT = 3'h0,
    ST_WAKE = 3'h1,
    ST_CONV = 3'h3,
    ST_DONE = 3'h2,
    ST_ACQ = 3'h6
  } scs_state_type;

  typedef struct packed {
    scs_state_type st;
    scs_mode_type mode;
    logic [7:0] cnt;
    logic [15:0] trial;
    logic [15:0] mask;
    logic [15:0] result;
    logic cvst_q;
    logic [15:0] idle;
    logic stale_cur;
    logic stale_res;
    logic [2:0] ists;
    logic [2:0] ien;
    logic dp_wr;
    logic [4:0] dp_addr;
    logic [31:0] rdata;
  } scs_seq_type;

  typedef struct packed {
    logic [7:0] cnt;
  } scs_div_type;
endpackage
`default_nettype wire

// >>> hdl/scs_tick_div.sv
`include "scs_params.svh"
`default_nettype none
module scs_tick_div
  import scs_pkg::*;
#(
  parameter int DIV = `SCS_TRIAL_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic en,
  output logic tick
);
  scs_div_type s, n;

  if (DIV < 2 || DIV > 255) begin : g_chk
    $error("scs_tick_div: DIV must be 2..255");
  end

  always_comb begin
    n = s;
    if (!en || s.cnt == 8'(DIV - 1)) begin
      n.cnt = 8'h00;
    end else begin
      n.cnt = s.cnt + 8'h01;
    end
  end

  // Restarts with every run, so the first trial is a full period long
  assign tick = en && (s.cnt == 8'(DIV - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  a_tick_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
    tick |=> !tick) else $error("trial ticks back to back");
endmodule
`default_nettype wire

// >>> hdl/scs_coder.sv
`include "scs_params.svh"
`default_nettype none
module scs_coder
  import scs_pkg::*;
(
  input wire logic [15:0] raw,
  input wire logic fmt_binary,
  input wire logic over,
  input wire logic under,
  output logic [15:0] code
);
  logic [15:0] sb;

  always_comb begin
    if (over) begin
      sb = `SCS_SB_MAX;
    end else if (under) begin
      sb = `SCS_SB_MIN;
    end else begin
      sb = raw;
    end
    code = fmt_binary ? sb : (sb ^ `SCS_TC_FLIP);
  end
endmodule
`default_nettype wire

// >>> hdl/scs_sequencer.sv
`include "scs_params.svh"
`default_nettype none
module scs_sequencer
  import scs_pkg::*;
#(
  parameter int TRIAL_DIV = `SCS_TRIAL_DIV,
  parameter int STALE_CYC = `SCS_STALE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic convert_start_n,
  input wire logic reset_in,
  input wire logic power_down_in,
  input wire logic code_format_select,
  input wire logic comp_in,
  input wire logic over_range,
  input wire logic under_range,
  output logic sample_hold,
  output logic [15:0] dac_code,
  output logic analog_power_en,
  output logic busy,
  output logic [15:0] result_out,
  output logic irq
);
  localparam int NB = `SCS_NBITS;
  localparam int CONV_CYC = NB * TRIAL_DIV;
  // Acquisition fills out the frame: trials + done cycle + acq count + exit
  localparam int ACQ_WARP = `SCS_PER_WARP_CYC - CONV_CYC - 2;
  localparam int ACQ_NORM = `SCS_PER_NORMAL_CYC - CONV_CYC - 2;
  localparam int WAKE_CYC = `SCS_WAKE_CYC;

  if (ACQ_WARP < 0 || ACQ_NORM < ACQ_WARP || WAKE_CYC < 1 || WAKE_CYC > 255) begin : g_chk
    $error("scs_sequencer: trial divider too slow for the rated modes");
  end
  if (STALE_CYC < 1 || STALE_CYC > 65535) begin : g_chk_stale
    $error("scs_sequencer: STALE_CYC must be 1..65535");
  end

  scs_seq_type s, n;
  logic tick;
  logic [15:0] coded;
  logic fall;
  logic start;
  logic addr_ph;
  logic [2:0] set_ev;
  logic [2:0] clr_ev;
  logic [31:0] rd;

  scs_tick_div #(
    .DIV(TRIAL_DIV)
  ) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(s.st == ST_CONV && !reset_in),
    .tick(tick)
  );

  scs_coder u_coder (
    .raw(s.trial),
    .fmt_binary(code_format_select),
    .over(over_range),
    .under(under_range),
    .code(coded)
  );

  assign busy = (s.st == ST_WAKE) || (s.st == ST_CONV) || (s.st == ST_DONE);
  assign sample_hold = busy;
  // Warp and normal keep the array live; low power and power-down only while busy
  assign analog_power_en = busy || (s.mode != MODE_LOWPWR && !power_down_in);
  assign dac_code = s.trial;
  assign result_out = s.result;
  assign irq = |(s.ists & s.ien);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign addr_ph = hsel && hready && htrans[1];

  always_comb begin
    n = s;
    start = 1'b0;
    set_ev = 3'h0;
    clr_ev = 3'h0;
    rd = 32'h0000_0000;
    fall = s.cvst_q && !convert_start_n;
    n.cvst_q = convert_start_n;
    if (s.idle != 16'(STALE_CYC)) begin
      n.idle = s.idle + 16'h0001;
    end

    case (s.st)
      ST_WAIT: begin
        start = fall;
      end
      ST_ACQ: begin
        if (s.cnt == 8'h00) begin
          n.st = ST_WAIT;
          start = !convert_start_n;
        end else begin
          n.cnt = s.cnt - 8'h01;
        end
      end
      ST_WAKE: begin
        if (s.cnt == 8'h00) begin
          n.st = ST_CONV;
        end else begin
          n.cnt = s.cnt - 8'h01;
        end
      end
      ST_CONV: begin
        if (tick) begin
          // Drop the trial bit when the comparator says too high
          n.trial = (comp_in ? s.trial : (s.trial & ~s.mask)) | (s.mask >> 1);
          n.mask = s.mask >> 1;
          if (s.mask == 16'h0001) begin
            n.st = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        n.result = coded;
        n.stale_res = s.stale_cur;
        n.st = ST_ACQ;
        n.cnt = (s.mode == MODE_WARP) ? 8'(ACQ_WARP) : 8'(ACQ_NORM);
        set_ev[`SCS_IRQ_DONE] = 1'b1;
      end
      default: begin
        n.st = ST_WAIT;
      end
    endcase

    if (start) begin
      if (power_down_in) begin
        set_ev[`SCS_IRQ_REFUSED] = 1'b1;
        n.st = ST_WAIT;
      end else begin
        n.st = (s.mode == MODE_LOWPWR) ? ST_WAKE : ST_CONV;
        n.cnt = 8'(WAKE_CYC - 1);
        n.trial = `SCS_TRIAL_MSB;
        n.mask = `SCS_TRIAL_MSB;
        // Only warp loses accuracy after a long gap; flagged for the host
        n.stale_cur = (s.mode == MODE_WARP) && (s.idle == 16'(STALE_CYC));
        n.idle = 16'h0000;
      end
    end

    if (reset_in) begin
      set_ev[`SCS_IRQ_ABORT] = busy;
      n.st = ST_WAIT;
      n.trial = 16'h0000;
      n.mask = 16'h0000;
    end

    if (s.dp_wr) begin
      case (s.dp_addr)
        `SCS_OFS_CTRL: n.mode = scs_mode_type'(hwdata[1:0]);
        `SCS_OFS_IRQ_EN: n.ien = hwdata[2:0];
        `SCS_OFS_IRQ_CLR: clr_ev = hwdata[2:0];
        default: n.ien = s.ien;
      endcase
    end
    // New events win over a clear in the same cycle
    n.ists = (s.ists & ~clr_ev) | set_ev;

    n.dp_wr = addr_ph && hwrite && hsize == 3'h2 && haddr[31:5] == 27'h000_0000;
    n.dp_addr = haddr[4:0];
    // Read mux sees this cycle's write to mode and interrupt enable, so write-then-read returns new data for those two
    if (haddr[31:5] == 27'h000_0000) begin
      case (haddr[4:0])
        `SCS_OFS_CTRL: rd = {30'h0000_0000, n.mode};
        `SCS_OFS_STATUS: begin
          rd[`SCS_STS_BUSY] = busy;
          rd[`SCS_STS_PDOWN] = power_down_in;
          rd[`SCS_STS_STALE] = s.stale_res;
        end
        `SCS_OFS_RESULT: rd = {16'h0000, s.result};
        `SCS_OFS_IRQ_STS: rd = {29'h0000_0000, s.ists};
        `SCS_OFS_IRQ_EN: rd = {29'h0000_0000, n.ien};
        default: rd = 32'h0000_0000;
      endcase
    end
    if (addr_ph && !hwrite) begin
      n.rdata = rd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.st <= ST_WAIT;
      s.mode <= scs_mode_type'(`SCS_CTRL_RST);
      s.ien <= `SCS_IEN_RST;
      s.cvst_q <= 1'b1;
      s.idle <= 16'(STALE_CYC);
    end else begin
      s <= n;
    end
  end

  localparam int CONV_MAX = NB * TRIAL_DIV;
  logic in_conv;
  logic st_done;
  assign in_conv = (s.st == ST_CONV);
  assign st_done = (s.st == ST_DONE);

  sequence s_conv_entry;
    $rose(in_conv);
  endsequence

  sequence s_finish;
    st_done ##1 !busy;
  endsequence

  a_start_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    s.st == ST_WAIT && fall && !power_down_in && !reset_in |=> busy && s.mask == 16'h8000)
    else $error("falling start edge did not begin a conversion");
  a_msb_first: assert property (@(posedge hclk) disable iff (!hresetn)
    s_conv_entry |-> s.mask == 16'h8000 && s.trial == 16'h8000)
    else $error("conversion did not open with the MSB trial");
  a_weight_halve: assert property (@(posedge hclk) disable iff (!hresetn)
    in_conv && tick && !reset_in |=> s.mask == ($past(s.mask) >> 1))
    else $error("trial weight did not halve");
  a_conv_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    s_conv_entry |-> ##[1:CONV_MAX] !in_conv)
    else $error("trials overran sixteen periods");
  a_done_result: assert property (@(posedge hclk) disable iff (!hresetn)
    st_done && !reset_in |=> !busy && result_out == $past(coded))
    else $error("result not latched as busy fell");
  a_no_latency: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(busy) && !$past(reset_in) |-> $past(st_done) && s.result == $past(coded))
    else $error("busy fell without a fresh result");
  a_sat_high: assert property (@(posedge hclk) disable iff (!hresetn)
    st_done && over_range && !reset_in |=> result_out == ($past(code_format_select)
      ? 16'hFFFF : 16'h7FFF)) else $error("overrange did not saturate high");
  a_sat_low: assert property (@(posedge hclk) disable iff (!hresetn)
    st_done && under_range && !over_range && !reset_in |=> result_out ==
      ($past(code_format_select) ? 16'h0000 : 16'h8000))
    else $error("underrange did not saturate low");
  a_format_msb: assert property (@(posedge hclk) disable iff (!hresetn)
    st_done && !over_range && !under_range |-> coded == (code_format_select
      ? s.trial : (s.trial ^ 16'h8000))) else $error("format select coding wrong");
  a_acq_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    s.st == ST_ACQ && s.cnt == 8'h00 && !convert_start_n && !power_down_in && !reset_in
      |=> busy) else $error("low start level at acquisition end ignored");
  a_busy_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    s_conv_entry ##0 (!reset_in)[*2] |-> busy)
    else $error("busy dropped during conversion");
  a_reset_abort: assert property (@(posedge hclk) disable iff (!hresetn)
    reset_in |=> !busy) else $error("reset input did not abort");
  a_pd_refuse: assert property (@(posedge hclk) disable iff (!hresetn)
    !busy && power_down_in |=> !busy) else $error("start taken in power-down");
  a_lp_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    s.mode == MODE_LOWPWR && !busy |-> !analog_power_en)
    else $error("analog left powered while idle");
  a_frame_end: assert property (@(posedge hclk) disable iff (!hresetn)
    st_done && !reset_in |-> s_finish) else $error("done cycle not followed by idle");
endmodule
`default_nettype wire

// >>> verification/scs_analog_model.sv
`default_nettype none
module scs_analog_model (
  input wire logic hclk,
  input wire logic sample_hold,
  input wire logic [15:0] dac_code,
  input wire logic [15:0] vin,
  output logic comp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] held_r = 16'h0000;
  logic junk_r = 1'b0;
  // Tracks the input until hold, then freezes it for the trials
  always_ff @(posedge hclk) begin
    junk_r <= ~junk_r;
    if (!sample_hold) begin
      held_r <= vin;
    end
  end
  // Outside hold the decision means nothing, so it toggles every cycle
  assign comp_in = sample_hold ? (held_r >= dac_code) : junk_r;
endmodule
`default_nettype wire

// >>> verification/sar_conversion_sequencer_test.sv
`default_nettype none
module sar_conversion_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] mode;
    logic fmt;
    logic [15:0] vin;
    logic ovr;
    logic und;
    logic [15:0] exp;
  } scs_row_type;
  // Short stale window keeps the run brief
  localparam int STALE = 50;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout, hresp, comp_in, sample_hold, analog_power_en, busy, irq;
  logic [31:0] hrdata, rd;
  logic [15:0] dac_code, result_out;
  logic convert_start_n = 1'b1;
  logic reset_in = 1'b0;
  logic power_down_in = 1'b0;
  logic code_format_select = 1'b1;
  logic over_range = 1'b0;
  logic under_range = 1'b0;
  logic [15:0] vin = 16'h0000;
  int error_cnt = 0;
  int checks_done = 0;
  int b;
  scs_row_type rows [11] = '{
    '{2'h0, 1'b1, 16'h8000, 1'b0, 1'b0, 16'h8000},
    '{2'h0, 1'b0, 16'h8000, 1'b0, 1'b0, 16'h0000},
    '{2'h1, 1'b1, 16'h1234, 1'b0, 1'b0, 16'h1234},
    '{2'h1, 1'b0, 16'h1234, 1'b0, 1'b0, 16'h9234},
    '{2'h2, 1'b1, 16'h0001, 1'b1, 1'b0, 16'hFFFF},
    '{2'h2, 1'b0, 16'h0001, 1'b1, 1'b0, 16'h7FFF},
    '{2'h0, 1'b1, 16'hFFFF, 1'b0, 1'b1, 16'h0000},
    '{2'h0, 1'b0, 16'hFFFF, 1'b0, 1'b1, 16'h8000},
    '{2'h3, 1'b1, 16'h0001, 1'b0, 1'b0, 16'h0001},
    '{2'h0, 1'b0, 16'h7FFF, 1'b0, 1'b0, 16'hFFFF},
    '{2'h1, 1'b1, 16'hFFFF, 1'b0, 1'b0, 16'hFFFF}};

  always #12.5 hclk = ~hclk;

  scs_sequencer #(.STALE_CYC(STALE)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .convert_start_n(convert_start_n), .reset_in(reset_in),
    .power_down_in(power_down_in), .code_format_select(code_format_select),
    .comp_in(comp_in), .over_range(over_range), .under_range(under_range),
    .sample_hold(sample_hold), .dac_code(dac_code), .analog_power_en(analog_power_en),
    .busy(busy), .result_out(result_out), .irq(irq)
  );

  scs_analog_model model_u (
    .hclk(hclk), .sample_hold(sample_hold), .dac_code(dac_code), .vin(vin),
    .comp_in(comp_in)
  );

  task summarize;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task tmo;
    error_cnt++;
    $display("wrong value at %0t: wait ran out", $time);
    summarize();
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
      if (k > 50) tmo();
    end while (hreadyout !== 1'b1);
  endtask

  // Single word transfer; the data phase is held until hready is seen high
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask

  task wait_lvl(input logic lvl, inout int n);
    int k;
    k = 0;
    while (busy !== lvl) begin
      @(negedge hclk);
      n++;
      k++;
      if (k > 300) tmo();
    end
  endtask

  task conv(input logic chk_dac, output int bc);
    @(posedge hclk);
    convert_start_n <= 1'b0;
    bc = 0;
    wait_lvl(1'b1, bc);
    if (chk_dac) chk(dac_code, 16'h8000);
    chk(sample_hold, 1'b1);
    chk(analog_power_en, 1'b1);
    bc = 0;
    wait_lvl(1'b0, bc);
    @(posedge hclk);
    convert_start_n <= 1'b1;
    repeat (24) @(posedge hclk);
  endtask

  // Start held low: each acquisition end restarts at once, so rise to rise is the frame
  task frame(input logic [1:0] m, input int exp);
    ahb(1'b1, 32'h0000_0000, {30'h0, m});
    @(posedge hclk);
    convert_start_n <= 1'b0;
    b = 0;
    wait_lvl(1'b1, b);
    b = 0;
    wait_lvl(1'b0, b);
    wait_lvl(1'b1, b);
    chk(b, exp);
    @(posedge hclk);
    convert_start_n <= 1'b1;
    repeat (60) @(posedge hclk);
    $display("test frame mode %0d done", m);
  endtask

  initial begin
    repeat (8) @(posedge hclk);
    chk({busy, sample_hold, irq, analog_power_en}, 4'h1);
    chk({dac_code, result_out}, 32'h0000_0000);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // Unmapped place reads zero
    ahb(1'b0, 32'h0000_001C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
    conv(1'b1, b);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk(rd[2], 1'b1);
    $display("test reset and stale done");
    foreach (rows[i]) begin
      ahb(1'b1, 32'h0000_0000, {30'h0, rows[i].mode});
      @(posedge hclk);
      code_format_select <= rows[i].fmt;
      vin <= rows[i].vin;
      over_range <= rows[i].ovr;
      under_range <= rows[i].und;
      conv(rows[i].mode != 2'h2, b);
      chk(b, (rows[i].mode == 2'h2) ? 41 : 33);
      chk(result_out, rows[i].exp);
      ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
      chk(rd, {16'h0000, rows[i].exp});
      if (rows[i].mode == 2'h2) chk(analog_power_en, 1'b0);
      $display("test row %0d done", i);
    end
    over_range <= 1'b0;
    under_range <= 1'b0;
    ahb(1'b0, 32'h0000_000C, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    chk(irq, 1'b0);
    ahb(1'b1, 32'h0000_0010, 32'h0000_0001);
    @(negedge hclk);
    chk(irq, 1'b1);
    ahb(1'b1, 32'h0000_0014, 32'h0000_0001);
    @(negedge hclk);
    chk(irq, 1'b0);
    ahb(1'b0, 32'h0000_0014, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    ahb(1'b1, 32'h0000_0010, 32'h0000_0007);
    $display("test interrupt done");
    frame(2'h1, 40);
    frame(2'h0, 50);
    ahb(1'b1, 32'h0000_0014, 32'h0000_0007);
    @(posedge hclk);
    convert_start_n <= 1'b0;
    repeat (6) @(posedge hclk);
    power_down_in <= 1'b1;
    b = 0;
    wait_lvl(1'b0, b);
    chk(b, 29);
    @(posedge hclk);
    convert_start_n <= 1'b1;
    repeat (24) @(posedge hclk);
    convert_start_n <= 1'b0;
    repeat (6) @(negedge hclk);
    chk(busy, 1'b0);
    ahb(1'b0, 32'h0000_000C, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    chk(irq, 1'b1);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk(rd[1], 1'b1);
    power_down_in <= 1'b0;
    convert_start_n <= 1'b1;
    ahb(1'b1, 32'h0000_0014, 32'h0000_0007);
    repeat (4) @(posedge hclk);
    $display("test power down done");
    convert_start_n <= 1'b0;
    repeat (10) @(posedge hclk);
    reset_in <= 1'b1;
    @(negedge hclk);
    @(negedge hclk);
    chk({busy, dac_code}, 17'h0_0000);
    @(posedge hclk);
    reset_in <= 1'b0;
    convert_start_n <= 1'b1;
    ahb(1'b0, 32'h0000_000C, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    repeat (24) @(posedge hclk);
    convert_start_n <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b0;
    @(negedge hclk);
    chk({busy, irq, result_out}, 18'h0_0000);
    @(posedge hclk);
    hresetn <= 1'b1;
    convert_start_n <= 1'b1;
    $display("test abort done");
    summarize();
  end
endmodule
`default_nettype wire
